//--- logic/rao_device.sv
// Device end: interrupt pin modes, alarm/frequency registers, scratch and up counter
//
// Functional notes
// R1: Fast select low decodes none, frequency, edge
// R2: Remaining codes give periodic1, alarm, periodic2
// R3: Fast select high outputs 32.768 kHz clock on pin A only
// R4: Data register is alarm time or frequency
// R5: Alarm bytes: weekday, hour, minute in BCD
// R6: Bit B0 of each byte enables match
// R7: Bits B7..B3 select frequencies, ANDed together
// R8: Low three bits are plain scratch storage
// R9: 1 Hz output follows seconds counter phase
// R10: Correction byte zero means no correction
// R11: Three independent scratch bytes
// R12: 24-bit up counter, zero at power-on
// R13: Soft init leaves up counter running
// R14: Up counter reads bit-reversed per byte
// R15: Date expansion with per-field enables
// R16: Power-on loads documented register values
// R17: Power-on flags and outputs 1 Hz
// R18: Soft init clears flag and frequency mode
// R19: Host initializes on reading flag set
// R20: Host reports missing power-on flag
// R21: Host sets alarm mode before alarm data
// R22: Host refuses nonexistent alarm day
// R23: Alarm holds pin low until enable cleared
module rao_device
	import rao_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	rao_link_if.dev         link,
	input  wire logic       clk32kLevel,
	input  wire logic       oneHzLevel,
	input  wire logic [3:0] freqTaps,
	input  wire logic       secondTick,
	input  wire logic       minuteTick,
	input  wire logic [7:0] curWeekday,
	input  wire logic [7:0] curHour,
	input  wire logic [7:0] curMinute,
	input  wire logic [7:0] curYear,
	input  wire logic [7:0] curMonth,
	input  wire logic [7:0] curDay
);
	typedef struct packed {
		logic [7:0]       mode;
		logic [1:0][23:0] almTime;
		logic [1:0][23:0] almDate;
		logic [7:0]       corr;
		logic [2:0][7:0]  scratch;
		logic [23:0]      upCnt;
		logic             pwrFlag;
		logic             ack;
		logic [23:0]      rdata;
		logic [5:0]       secCnt;
		logic [1:0]       matchPrev;
		logic [1:0]       hit;
		logic [1:0]       minLatch;
		logic [1:0]       pinLow;
	} rao_dev_state_type;

	localparam rao_dev_state_type DEV_POR = '{
		mode:    MODE_POR,
		almTime: {24'h000000, ALM1_POR},
		pwrFlag: 1'b1,
		default: '0
	};
	localparam rao_dev_state_type DEV_INIT = '{default: '0};

	rao_dev_state_type s_r;
	rao_dev_state_type s_nxt;
	rao_pinmode_type   pm [2];
	logic [1:0]        match;
	logic [1:0]        freqOut;

	always_comb begin
		logic [23:0] t;
		logic [23:0] d;
		logic [23:0] keepCnt;
		t = '0;
		d = '0;
		keepCnt = '0;
		s_nxt = s_r;
		s_nxt.ack = link.req & ~s_r.ack;

		// Second position within the minute, for the periodic modes
		if (minuteTick) begin
			s_nxt.secCnt = '0;
		end else if (secondTick && s_r.secCnt != SEC_LAST) begin
			s_nxt.secCnt = s_r.secCnt + 6'h01;
		end
		if (minuteTick) begin
			s_nxt.upCnt = s_r.upCnt + 24'h000001; // [R12]
		end

		pm[0] = decodeMode(s_r.mode[MB_FAST], s_r.mode[MB_A1AE],
			s_r.mode[MB_ALARM1_MONTH_MATCH_EN], s_r.mode[MB_A1FE], 1'b1); // [R1] [R2] [R3]
		pm[1] = decodeMode(1'b0, s_r.mode[MB_A2AE],
			s_r.mode[MB_ALARM2_MONTH_MATCH_EN], s_r.mode[MB_A2FE], 1'b0);

		for (int i = 0; i < 2; i++) begin
			t = s_r.almTime[i];
			d = s_r.almDate[i];
			match[i] = fieldOk(t[16+EN_BIT], t[23:16], curWeekday, WDAY_MASK) // [R5] [R6]
				& fieldOk(t[8+EN_BIT], t[15:8], curHour, HM_MASK)
				& fieldOk(t[EN_BIT], t[7:0], curMinute, HM_MASK)
				& fieldOk(d[8+YE_BIT], d[23:16], curYear, YEAR_MASK) // [R15]
				& fieldOk(d[8+EN_BIT], d[15:8], curMonth, MON_MASK)
				& fieldOk(d[EN_BIT], d[7:0], curDay, DAY_MASK);
			// Unselected sources count as high; B7 is the seconds-phased 1 Hz
			freqOut[i] = &({oneHzLevel, freqTaps} | ~t[7:FREQ_LO]); // [R7] [R9] [R4]
			s_nxt.matchPrev[i] = match[i];
			// Only a fresh match fires: re-enabling inside a match stays quiet
			s_nxt.hit[i] = (pm[i] == PM_ALARM)
				& (s_r.hit[i] | (match[i] & ~s_r.matchPrev[i])); // [R23]
			s_nxt.minLatch[i] = (pm[i] == PM_MINEDGE) & (s_r.minLatch[i] | minuteTick);
			unique case (pm[i])
				PM_NONE:    s_nxt.pinLow[i] = 1'b0;
				PM_FREQ:    s_nxt.pinLow[i] = ~freqOut[i]; // [R17]
				PM_MINEDGE: s_nxt.pinLow[i] = s_r.minLatch[i];
				PM_PERIOD1: s_nxt.pinLow[i] = (s_r.secCnt < SEC_HALF); // [R2]
				PM_ALARM:   s_nxt.pinLow[i] = s_r.hit[i]; // [R23]
				PM_PERIOD2: s_nxt.pinLow[i] = (s_r.secCnt == 6'h00);
				PM_CLK32:   s_nxt.pinLow[i] = ~clk32kLevel; // [R3]
				default:    s_nxt.pinLow[i] = 1'b0;
			endcase
		end

		if (s_nxt.ack) begin
			unique case (link.addr)
				REG_MODE:   s_nxt.rdata = {16'h0000, s_r.mode};
				REG_ALM1:   s_nxt.rdata = s_r.almTime[0];
				REG_ALM2:   s_nxt.rdata = s_r.almTime[1];
				REG_CORR:   s_nxt.rdata = {16'h0000, s_r.corr};
				REG_SCR1:   s_nxt.rdata = {16'h0000, s_r.scratch[0]};
				REG_SCR2:   s_nxt.rdata = {16'h0000, s_r.scratch[1]};
				REG_SCR3:   s_nxt.rdata = {16'h0000, s_r.scratch[2]};
				REG_UPCNT:  s_nxt.rdata = {rev8(s_r.upCnt[23:16]), rev8(s_r.upCnt[15:8]),
					rev8(s_r.upCnt[7:0])}; // [R14]
				REG_ADATE1: s_nxt.rdata = s_r.almDate[0];
				REG_ADATE2: s_nxt.rdata = s_r.almDate[1];
				REG_STATUS: s_nxt.rdata = {20'h00000, s_r.hit[0], s_r.hit[1],
					1'b0, s_r.pwrFlag};
				default:    s_nxt.rdata = '0;
			endcase
			if (link.wr) begin
				unique case (link.addr)
					REG_MODE:   s_nxt.mode = link.wdata[7:0];
					REG_ALM1:   s_nxt.almTime[0] = link.wdata; // [R4] [R8]
					REG_ALM2:   s_nxt.almTime[1] = link.wdata;
					REG_CORR:   s_nxt.corr = link.wdata[7:0]; // [R10]
					REG_SCR1:   s_nxt.scratch[0] = link.wdata[7:0]; // [R11]
					REG_SCR2:   s_nxt.scratch[1] = link.wdata[7:0];
					REG_SCR3:   s_nxt.scratch[2] = link.wdata[7:0];
					REG_ADATE1: s_nxt.almDate[0] = link.wdata; // [R15]
					REG_ADATE2: s_nxt.almDate[1] = link.wdata;
					default: ;
				endcase
				if (link.addr == REG_STATUS && link.wdata[ST_INIT]) begin
					// Counter survives and ack stays set; everything else returns to zero
					keepCnt = s_nxt.upCnt; // [R13]
					s_nxt = DEV_INIT; // [R18]
					s_nxt.upCnt = keepCnt;
					s_nxt.ack = 1'b1;
				end
			end else if (link.addr == REG_STATUS) begin
				s_nxt.pwrFlag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= DEV_POR; // [R16] [R17] [R12]
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.ack     = s_r.ack;
	assign link.rdata   = s_r.rdata;
	assign link.irqAOut = 1'b0;
	assign link.irqBOut = 1'b0;
	assign link.irqAOeN = ~s_r.pinLow[0];
	assign link.irqBOeN = ~s_r.pinLow[1];
endmodule

//--- logic/rao_host.sv
// Host end: APB-commanded controller that drives the device link
//
// Design decisions made here: the APB interface to the registers and the address map.
module rao_host
	import rao_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	rao_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum logic [2:0] {
		HS_CHECK, HS_INIT, HS_CORR, HS_IDLE, HS_USER, HS_AMODE, HS_ATIME, HS_ADATE
	} rao_hstate_type;

	typedef struct packed {
		rao_hstate_type state;
		logic           req;
		logic           wr;
		logic [3:0]     addr;
		logic [23:0]    wdata;
		logic [23:0]    wdataReg;
		logic [23:0]    rdataReg;
		logic [3:0]     cmdAddr;
		logic           cmdWr;
		logic [23:0]    almTime;
		logic [23:0]    almDate;
		logic [7:0]     goMode;
		logic           goCh;
		logic           powerFault;
		logic           refused;
	} rao_host_state_type;

	rao_host_state_type s_r;
	rao_host_state_type s_nxt;

	function automatic logic dayBad(input logic [7:0] b);
		logic [7:0] r;
		r = rev8(b);
		dayBad = b[EN_BIT] && (r[3:0] > BCD_NINE || r[5:4] == 2'h0 && r[3:0] == 4'h0
			|| r[5:4] == DAY_T_MAX && r[3:0] > DAY_U_MAX);
	endfunction

	always_comb begin
		logic           opWr;
		logic [3:0]     opAddr;
		logic [23:0]    opData;
		rao_hstate_type after;
		logic           apbWr;
		opWr = 1'b1;
		opAddr = REG_STATUS;
		opData = '0;
		after = HS_IDLE;
		apbWr = psel & penable & pwrite;
		s_nxt = s_r;

		unique case (s_r.state)
			HS_CHECK: begin
				opWr = 1'b0;
				after = link.rdata[ST_PWR] ? HS_INIT : HS_IDLE; // [R19]
			end
			HS_INIT: begin
				opData[ST_INIT] = 1'b1;
				after = HS_CORR;
			end
			HS_CORR: begin
				opAddr = REG_CORR;
				opData = {16'h0000, CORR_NONE}; // [R10]
			end
			HS_USER: begin
				opWr = s_r.cmdWr;
				opAddr = s_r.cmdAddr;
				opData = s_r.wdataReg;
				after = (!s_r.cmdWr && s_r.cmdAddr == REG_STATUS && link.rdata[ST_PWR])
					? HS_INIT : HS_IDLE; // [R19]
			end
			HS_AMODE: begin
				opAddr = REG_MODE;
				opData = {16'h0000, s_r.goMode}; // [R21]
				after = HS_ATIME;
			end
			HS_ATIME: begin
				opAddr = s_r.goCh ? REG_ALM2 : REG_ALM1;
				opData = s_r.almTime;
				after = HS_ADATE;
			end
			HS_ADATE: begin
				opAddr = s_r.goCh ? REG_ADATE2 : REG_ADATE1;
				opData = s_r.almDate;
			end
			HS_IDLE: ;
		endcase

		if (s_r.state != HS_IDLE) begin
			if (!s_r.req) begin
				s_nxt.req = 1'b1;
				s_nxt.wr = opWr;
				s_nxt.addr = opAddr;
				s_nxt.wdata = opData;
			end else if (link.ack) begin
				s_nxt.req = 1'b0;
				s_nxt.state = after;
				if (!s_r.wr) begin
					s_nxt.rdataReg = link.rdata;
				end
				if (s_r.state == HS_CHECK && !link.rdata[ST_PWR]) begin
					s_nxt.powerFault = 1'b1; // [R20]
				end
			end
		end

		if (apbWr) begin
			unique case (paddr)
				HA_WDATA:   s_nxt.wdataReg = pwdata[23:0];
				HA_ALMTIME: s_nxt.almTime = pwdata[23:0];
				HA_ALMDATE: s_nxt.almDate = pwdata[23:0];
				HA_CMD: begin
					if (s_r.state == HS_IDLE) begin
						s_nxt.cmdAddr = pwdata[3:0];
						s_nxt.cmdWr = pwdata[CMD_WR_BIT];
						s_nxt.state = HS_USER;
					end
				end
				HA_ALMGO: begin
					if (s_r.state == HS_IDLE) begin
						s_nxt.refused = dayBad(s_r.almDate[7:0]); // [R22]
						s_nxt.goMode = pwdata[7:0];
						s_nxt.goCh = pwdata[GO_CH_BIT];
						if (!s_nxt.refused) begin
							s_nxt.state = HS_AMODE; // [R21]
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{state: HS_CHECK, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	always_comb begin
		unique case (paddr)
			HA_WDATA:   prdata = {8'h00, s_r.wdataReg};
			HA_STAT:    prdata = {27'h0000000, link.irqBLevel, link.irqALevel,
				s_r.refused, s_r.powerFault, s_r.state != HS_IDLE};
			HA_RDATA:   prdata = {8'h00, s_r.rdataReg};
			HA_ALMTIME: prdata = {8'h00, s_r.almTime};
			HA_ALMDATE: prdata = {8'h00, s_r.almDate};
			default:    prdata = 32'h00000000;
		endcase
	end

	assign pready     = 1'b1;
	assign pslverr    = 1'b0;
	assign link.req   = s_r.req;
	assign link.wr    = s_r.wr;
	assign link.addr  = s_r.addr;
	assign link.wdata = s_r.wdata;
endmodule

//--- logic/rao_link_if.sv
// Register link and open-drain interrupt pins between host and device
interface rao_link_if;
	logic        req;
	logic        wr;
	logic [3:0]  addr;
	logic [23:0] wdata;
	logic        ack;
	logic [23:0] rdata;
	logic        irqAOut;
	logic        irqAOeN;
	logic        irqBOut;
	logic        irqBOeN;
	logic        irqALevel;
	logic        irqBLevel;

	// Pull-up resolves the open-drain wire
	assign irqALevel = irqAOeN ? 1'b1 : irqAOut;
	assign irqBLevel = irqBOeN ? 1'b1 : irqBOut;

	modport dev (input req, wr, addr, wdata,
		output ack, rdata, irqAOut, irqAOeN, irqBOut, irqBOeN);
	modport host (output req, wr, addr, wdata,
		input ack, rdata, irqALevel, irqBLevel);
endinterface

//--- logic/rao_pkg.sv
// Shared constants, types and decode helpers for the alarm/output register block
package rao_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 24;

	// Device register indices on the link
	localparam logic [3:0] REG_MODE    = 4'h0;
	localparam logic [3:0] REG_ALM1    = 4'h1;
	localparam logic [3:0] REG_ALM2    = 4'h2;
	localparam logic [3:0] REG_CORR    = 4'h3;
	localparam logic [3:0] REG_SCR1    = 4'h4;
	localparam logic [3:0] REG_SCR2    = 4'h5;
	localparam logic [3:0] REG_SCR3    = 4'h6;
	localparam logic [3:0] REG_UPCNT   = 4'h7;
	localparam logic [3:0] REG_ADATE1  = 4'h8;
	localparam logic [3:0] REG_ADATE2  = 4'h9;
	localparam logic [3:0] REG_STATUS  = 4'ha;

	localparam logic [7:0]  MODE_POR   = 8'h80;
	localparam logic [23:0] ALM1_POR   = 24'h000080;
	localparam logic [7:0]  CORR_NONE  = 8'h00;

	// Mode register bit positions
	localparam int MB_A2AE = 1;
	localparam int MB_ALARM2_MONTH_MATCH_EN = 2;
	localparam int MB_A2FE = 3;
	localparam int MB_FAST = 4;
	localparam int MB_A1AE = 5;
	localparam int MB_ALARM1_MONTH_MATCH_EN = 6;
	localparam int MB_A1FE = 7;

	// Status register bit positions
	localparam int ST_PWR  = 0;
	localparam int ST_HITB = 2;
	localparam int ST_HITA = 3;
	localparam int ST_INIT = 7;

	// Alarm byte layout
	localparam int EN_BIT  = 0;
	localparam int YE_BIT  = 1;
	localparam int FREQ_LO = 3;
	localparam logic [7:0] WDAY_MASK = 8'he0;
	localparam logic [7:0] HM_MASK   = 8'hfe;
	localparam logic [7:0] YEAR_MASK = 8'hff;
	localparam logic [7:0] MON_MASK  = 8'hf8;
	localparam logic [7:0] DAY_MASK  = 8'hfc;

	localparam logic [5:0] SEC_HALF  = 6'h1e;
	localparam logic [5:0] SEC_LAST  = 6'h3b;
	localparam logic [3:0] BCD_NINE  = 4'h9;
	localparam logic [3:0] DAY_U_MAX = 4'h1;
	localparam logic [1:0] DAY_T_MAX = 2'h3;

	// Host register byte offsets
	localparam logic [7:0] HA_WDATA   = 8'h00;
	localparam logic [7:0] HA_CMD     = 8'h04;
	localparam logic [7:0] HA_STAT    = 8'h08;
	localparam logic [7:0] HA_RDATA   = 8'h0c;
	localparam logic [7:0] HA_ALMGO   = 8'h10;
	localparam logic [7:0] HA_ALMTIME = 8'h14;
	localparam logic [7:0] HA_ALMDATE = 8'h18;
	localparam int CMD_WR_BIT = 8;
	localparam int GO_CH_BIT  = 8;

	typedef enum logic [2:0] {
		PM_NONE, PM_FREQ, PM_MINEDGE, PM_PERIOD1, PM_ALARM, PM_PERIOD2, PM_CLK32
	} rao_pinmode_type;

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = b[7-i];
		end
	endfunction

	function automatic logic fieldOk(input logic en, input logic [7:0] a,
			input logic [7:0] c, input logic [7:0] mask);
		fieldOk = !en || (((a ^ c) & mask) == 8'h00);
	endfunction

	function automatic rao_pinmode_type decodeMode(input logic fast, input logic ae,
			input logic me, input logic fe, input logic pinA);
		if (fast && pinA) begin
			decodeMode = PM_CLK32;
		end else if (!me && fe) begin
			decodeMode = PM_FREQ;
		end else if (me && !fe) begin
			decodeMode = PM_MINEDGE;
		end else if (me && fe) begin
			decodeMode = (ae && pinA) ? PM_PERIOD2 : PM_PERIOD1;
		end else begin
			decodeMode = ae ? PM_ALARM : PM_NONE;
		end
	endfunction
endpackage

//--- verif/rao_link_chk.sv
// Protocol checker for the register link and the open-drain pins
module rao_link_chk (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        req,
	input wire logic        wr,
	input wire logic [3:0]  addr,
	input wire logic [23:0] wdata,
	input wire logic        ack,
	input wire logic [23:0] rdata,
	input wire logic        irqAOut,
	input wire logic        irqAOeN,
	input wire logic        irqBOut,
	input wire logic        irqBOeN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_ack_prompt: assert property ($rose(req) |=> ack)
		else $error("ack not one cycle after request");
	a_ack_cause: assert property (ack |-> $past(req) && req)
		else $error("ack without request");
	a_req_release: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(wr)
		&& $stable(wdata))
		else $error("request changed before ack");
	a_req_gap: assert property ($fell(req) |-> $past(ack) && !ack)
		else $error("request dropped without ack");
	a_rdata_hold: assert property (!ack |-> $stable(rdata))
		else $error("read data changed outside ack");
	a_unmapped_zero: assert property (ack && !wr && addr > 4'ha |-> rdata == 24'h000000)
		else $error("unmapped read not zero");
	a_pins_od: assert property ((irqAOeN || !irqAOut) && (irqBOeN || !irqBOut))
		else $error("pin driven high");
endmodule

//--- verif/tb.sv
// Testbench: host and device joined by the link, APB stimulus, register model
module tb
	import rao_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, k32 = 0, hz = 0, sTick = 0, mTick = 0;
	logic [3:0]  taps = 4'h0;
	logic [7:0]  wd = 8'h00, hr = 8'h00, mi = 8'h00, yr = 8'h00, mo = 8'h00, dy = 8'h00;
	int          fails = 0, comparisons = 0, cyc = 0, seed = 39, cnt = 0;
	int          mdl[16];

	rao_link_if lnk();
	rao_device u_rao_device (.clk(clk), .rst_b(rst_b), .link(lnk), .clk32kLevel(k32),
		.oneHzLevel(hz), .freqTaps(taps), .secondTick(sTick), .minuteTick(mTick),
		.curWeekday(wd), .curHour(hr), .curMinute(mi), .curYear(yr), .curMonth(mo),
		.curDay(dy));
	rao_host u_rao_host (.clk(clk), .rst_b(rst_b), .link(lnk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	rao_link_chk u_chk (.clk(clk), .rst_b(rst_b), .req(lnk.req), .wr(lnk.wr),
		.addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata),
		.irqAOut(lnk.irqAOut), .irqAOeN(lnk.irqAOeN), .irqBOut(lnk.irqBOut),
		.irqBOeN(lnk.irqBOeN));

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			fails++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until pready is sampled high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", 32'h0, {31'h0, pslverr});
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(0, HA_STAT, 0);
			n++;
		end while (rd[0] !== 1'b0 && n < 60);
	endtask

	task automatic dev(input logic w, input logic [3:0] i, input logic [23:0] d);
		apb(1, HA_WDATA, {8'h00, d});
		apb(1, HA_CMD, {23'h0, w, 4'h0, i});
		idle();
		apb(0, HA_RDATA, 0);
	endtask

	// Pins sampled mid-cycle, then seen again through the status word
	task automatic pin(input logic e, input logic f = 1'b1);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("pinA", {31'h0, e}, {31'h0, lnk.irqALevel});
		chk("pinB", {31'h0, f}, {31'h0, lnk.irqBLevel});
		apb(0, HA_STAT, 0);
		chk("statPins", {30'h0, f, e}, {30'h0, rd[4:3]});
	endtask

	function automatic logic [7:0] flip(input logic [7:0] b);
		for (int i = 0; i < 8; i++) flip[i] = b[7-i];
	endfunction

	function automatic logic [31:0] mread(input int i);
		logic [23:0] c;
		c = cnt[23:0];
		if (i == 7) return {8'h00, flip(c[23:16]), flip(c[15:8]), flip(c[7:0])};
		if (i == 1 || i == 2 || i == 8 || i == 9) return mdl[i] & 32'hffffff;
		if (i < 7) return mdl[i] & 32'hff;
		return 0;
	endfunction

	task automatic readAll(input string nm);
		for (int i = 0; i < 16; i++) begin
			if (i != 10) begin
				dev(0, i[3:0], 0);
				chk(nm, mread(i), rd);
			end
		end
	endtask

	// Power-on state is only visible before the host's own init lands
	task automatic boot(input string nm);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("pinA", {31'h0, hz}, {31'h0, lnk.irqALevel});
		chk("flag", 32'h1, {8'h00, lnk.rdata});
		idle();
		chk("powerFault", 32'h0, {31'h0, rd[1]});
		readAll(nm);
	endtask

	initial begin
		logic [23:0] v;
		for (int i = 0; i < 16; i++) mdl[i] = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		// Boot reads the flag, initializes and clears the correction byte
		boot("init");
		$display("test boot done");
		for (int i = 0; i < 16; i++) begin
			v = 24'($random(seed));
			if (i != 10) dev(1, i[3:0], v);
			if (i != 7) mdl[i] = v;
		end
		readAll("rw");
		$display("test registers done");
		repeat (258) begin
			@(posedge clk) mTick <= 1'b1;
			@(posedge clk) mTick <= 1'b0;
		end
		cnt = 258;
		dev(0, REG_UPCNT, 0);
		chk("upcnt", mread(7), rd);
		dev(1, REG_STATUS, 24'h000080);
		for (int i = 0; i < 16; i++) mdl[i] = 0;
		readAll("softinit");
		$display("test counter done");
		dev(1, REG_MODE, 24'h000010);
		for (int j = 0; j < 4; j++) begin
			k32 <= j[0];
			pin(j[0]);
		end
		dev(1, REG_ALM1, 24'h000088);
		dev(1, REG_MODE, 24'h000080);
		for (int j = 0; j < 4; j++) begin
			hz <= j[0];
			taps[0] <= j[1];
			pin(j[0] & j[1]);
		end
		dev(1, REG_MODE, 24'h000000);
		pin(1'b1);
		dev(1, REG_MODE, 24'h000040);
		pin(1'b1);
		@(posedge clk) mTick <= 1'b1;
		@(posedge clk) mTick <= 1'b0;
		pin(1'b0);
		$display("test pin modes done");
		mi <= 8'h20;
		dev(1, REG_MODE, 24'h000000);
		dev(1, REG_ALM1, 24'h000000);
		dev(1, REG_ADATE1, 24'h000000);
		dev(1, REG_MODE, 24'h000020);
		hr <= 8'h12;
		dev(1, REG_ALM1, 24'h761331);
		pin(1'b1);
		mi <= 8'h30;
		pin(1'b0);
		mi <= 8'h20;
		pin(1'b0);
		dev(1, REG_MODE, 24'h000000);
		pin(1'b1);
		$display("test alarm done");
		apb(1, HA_ALMDATE, 32'h00000001);
		apb(1, HA_ALMGO, 32'h00000020);
		apb(0, HA_STAT, 0);
		chk("refused", 32'h1, {31'h0, rd[2]});
		apb(1, HA_ALMTIME, 32'h00000031);
		apb(1, HA_ALMDATE, 32'h0000008d);
		apb(1, HA_ALMGO, 32'h00000020);
		idle();
		chk("refused", 32'h0, {31'h0, rd[2]});
		dev(0, REG_MODE, 0);
		chk("goMode", 32'h20, rd);
		dev(0, REG_ALM1, 0);
		chk("goTime", 32'h31, rd);
		dev(0, REG_ADATE1, 0);
		chk("goDate", 32'h8d, rd);
		pin(1'b1);
		dy <= 8'h8d;
		mi <= 8'h31;
		pin(1'b0);
		dev(0, REG_STATUS, 0);
		chk("alarmFlag", 32'h8, rd);
		$display("test alarm program done");
		dev(1, REG_MODE, 24'h0000c0);
		@(posedge clk) mTick <= 1'b1;
		@(posedge clk) mTick <= 1'b0;
		pin(1'b0);
		repeat (30) begin
			@(posedge clk) sTick <= 1'b1;
			@(posedge clk) sTick <= 1'b0;
		end
		pin(1'b1);
		dev(1, REG_MODE, 24'h0000e0);
		pin(1'b1);
		@(posedge clk) mTick <= 1'b1;
		@(posedge clk) mTick <= 1'b0;
		pin(1'b0);
		dev(1, REG_ALM2, 24'h000080);
		dev(1, REG_MODE, 24'h000008);
		hz <= 1'b0;
		pin(1'b1, 1'b0);
		hz <= 1'b1;
		pin(1'b1, 1'b1);
		$display("test periodic done");
		// Second power-on mid-run: counter must restart from zero
		@(posedge clk) rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		cnt = 0;
		boot("reboot");
		$display("test reboot done");
		summarize();
	end
endmodule
